//--- src/baf_defines.vh
// offsets, field positions, sizes, response codes and timing for the address filter
// assumes a 32-bit AXI4-Lite slave, one aligned word per register
`ifndef BAF_DEFINES_VH
`define BAF_DEFINES_VH
`define BAF_CLK_NS 25
`define BAF_SEC_NS 1000000000
`define BAF_TBL_AW 13
`define BAF_STATIC_MAX 200
`define BAF_NFILT 100
// register byte offsets
`define BAF_PORT_EN 8'h00
`define BAF_EN_CMD 8'h04
`define BAF_DIS_CMD 8'h08
`define BAF_MAC_LO 8'h0C
`define BAF_MAC_HI 8'h10
`define BAF_TBL_CMD 8'h14
`define BAF_TBL_STAT 8'h18
`define BAF_RESTR 8'h1C
`define BAF_DMAC_LO 8'h20
`define BAF_MCL 8'h24
`define BAF_FILT_CMD 8'h28
`define BAF_PSEUDO_CNT 8'h2C
`define BAF_LOOKUP 8'h30
`define BAF_DMAC_HI 8'h34
`define BAF_BSET 8'h40
`define BAF_STATS 8'h60
// table command fields
`define BAF_OP_ADD 2'h0
`define BAF_OP_DEL 2'h1
`define BAF_OP_LOOK 2'h2
`define BAF_CMD_OP 9:8
`define BAF_CMD_NUL 4
`define BAF_CMD_SF 5
`define BAF_CMD_MSF 6
// entry layout
`define BAF_E_STAMP 63:48
`define BAF_E_PORT 66:64
`define BAF_E_NUL 67
`define BAF_E_MSF 68
`define BAF_E_SF 69
`define BAF_E_STAT 70
`define BAF_E_VLD 71
`define BAF_RESP_OK 2'h0
`define BAF_RESP_ERR 2'h2
`endif

//--- src/bridge_address_filter.v
// frame filtering stage: address table, port filters, port enables
// assumes frame descriptors and registers on the single aclk domain
`timescale 1ns/1ps
`include "baf_defines.vh"

// Overview of operation
// [RQ1] hashed address table of 8192 entries
// [RQ2] at most 200 static entries
// [RQ3] entry holds port, learned or management set
// [RQ4] entry age from last-seen seconds stamp
// [RQ5] source filter flag drops matching source
// [RQ6] multicast source flag drops its multicasts
// [RQ7] group bit of destination means multicast
// [RQ8] static null destination drops the frame
// [RQ9] static port beats learned port
// [RQ10] broadcast forwarded per receive-port set
// [RQ11] static-only port keeps static sources only
// [RQ12] same source and destination becomes broadcast
// [RQ13] entry filter drops when all fields match
// [RQ14] exit multicast limit per interval
// [RQ15] exit filter drops when all fields match
// [RQ16] pool of 100 shared port filters; filter 0 is stored but never applied
// [RQ17] re-enable keeps stored port configuration
// [RQ18] enabling an enabled port clears statistics
// [RQ19] disabled port bridges nothing, survives reset; only the warm reset, as cold reset re-enables every port
// [RQ20] pseudo filter counts, never blocks
// [RQ21] unknown source learned into any slot not holding a static entry
// [RQ22] unfiltered frame forwarded by destination
module bridge_address_filter #(
  parameter NP = 8,
  parameter SEC_CYCLES = `BAF_SEC_NS / `BAF_CLK_NS
) (
  // clock, resets, enable
  input wire aclk,
  input wire aresetn,
  input wire cold_rst_n,
  input wire ce,
  // axi4-lite slave
  input wire [7:0] s_awaddr,
  input wire s_awvalid,
  output reg s_awready,
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output reg s_wready,
  output reg [1:0] s_bresp,
  output reg s_bvalid,
  input wire s_bready,
  input wire [7:0] s_araddr,
  input wire s_arvalid,
  output reg s_arready,
  output reg [31:0] s_rdata,
  output reg [1:0] s_rresp,
  output reg s_rvalid,
  input wire s_rready,
  // frame descriptor in
  input wire in_valid,
  output reg in_ready,
  input wire [47:0] in_src,
  input wire [47:0] in_dst,
  input wire [2:0] in_port,
  // forwarding decision out
  output reg out_valid,
  output reg out_drop,
  output reg [NP-1:0] out_mask
);
  localparam AW = `BAF_TBL_AW;
  localparam NF = `BAF_NFILT;
  localparam S_IDLE = 3'd0, S_SRC = 3'd1, S_DST = 3'd2, S_FILT = 3'd3;
  localparam S_OUT = 3'd4, S_MG1 = 3'd5, S_MG2 = 3'd6;

  function [AW-1:0] hsh;
    input [47:0] m;
    hsh = m[12:0] ^ m[25:13] ^ m[38:26] ^ {4'h0, m[47:39]};
  endfunction

  reg [71:0] tbl [0:(1<<AW)-1]; // [RQ1]
  reg [11:0] fcfg [0:NF-1]; // [RQ16]
  reg [47:0] fsrc [0:NF-1];
  reg [47:0] fdst [0:NF-1];
  reg [NP-1:0] bset [0:NP-1];
  reg [15:0] stat [0:NP-1];
  reg [7:0] mcc [0:NP-1];
  reg [NP-1:0] port_en_q;
  reg [47:0] mac_q, dmac_q;
  reg [15:0] restr_q;
  reg [23:0] mcl_q;
  reg [15:0] pseudo_q;
  reg [31:0] look_q;
  reg [9:0] cmd_q;
  reg cmd_pend_q, full_err_q;
  reg [7:0] scnt_q;
  reg [2:0] st_q;
  reg [71:0] rd_q;
  reg [AW-1:0] addr_q;
  reg [47:0] src_q, dst_q;
  reg [2:0] rxp_q;
  reg drop_q, src_stat_q;
  reg [NP-1:0] mask_q;
  reg [6:0] fi_q;
  reg [31:0] tick_q;
  reg [15:0] now_q;
  reg [7:0] int_q;
  reg aw_h_q, w_h_q;
  reg [7:0] awa_q;
  reg [31:0] wd_q;
  integer i;

  wire [71:0] rd = rd_q;
  wire hit = rd[`BAF_E_VLD] && rd[47:0] == src_q;
  wire dhit = rd[`BAF_E_VLD] && rd[47:0] == dst_q;
  wire mcast = dst_q[40]; // [RQ7]
  wire bcast = &dst_q;
  wire [11:0] fc = fcfg[fi_q];
  wire f_src_ok = !fc[10] || fsrc[fi_q] == src_q;
  wire f_dst_ok = !fc[11] || fdst[fi_q] == dst_q;
  wire f_rxp_ok = !fc[6] || fc[9:7] == rxp_q;
  wire f_all = fc[0] && f_src_ok && f_dst_ok;
  wire wr_go = aw_h_q && w_h_q && !s_bvalid;
  wire tbl_go = wr_go && awa_q == `BAF_TBL_CMD;
  wire sec_tick = tick_q == SEC_CYCLES - 1;
  reg [NP-1:0] dmask;

  // destination mask from table result and loopback handling
  always @*
  begin
    dmask = {NP{1'b1}};
    if (bcast || (restr_q[8+rxp_q] && src_q == dst_q)) // [RQ12]
      dmask = bset[rxp_q]; // [RQ10]
    else if (dhit && rd[`BAF_E_NUL])
      dmask = {NP{1'b0}}; // [RQ8]
    else if (dhit && !mcast)
      dmask = {{(NP-1){1'b0}}, 1'b1} << rd[`BAF_E_PORT]; // [RQ9] [RQ22]
    dmask[rxp_q] = 1'b0;
  end

  // seconds tick drives ages and multicast intervals
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_q <= 32'h0;
      now_q <= 16'h0;
    end
    else if (ce)
    begin
      tick_q <= sec_tick ? 32'h0 : tick_q + 32'h1;
      if (sec_tick)
        now_q <= now_q + 16'h1;
    end
  end

  // enable state is kept across the warm reset on purpose
  always @(posedge aclk)
  begin
    if (!cold_rst_n)
      port_en_q <= {NP{1'b1}};
    else if (ce && wr_go && awa_q == `BAF_EN_CMD)
      port_en_q <= port_en_q | wd_q[NP-1:0]; // [RQ17]
    else if (ce && wr_go && awa_q == `BAF_DIS_CMD)
      port_en_q <= port_en_q & ~wd_q[NP-1:0]; // [RQ19]
  end

  // axi write channel: address and data taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= `BAF_RESP_OK;
      aw_h_q <= 1'b0;
      w_h_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0;
    end
    else if (ce)
    begin
      if (s_awvalid && s_awready)
      begin
        awa_q <= s_awaddr;
        aw_h_q <= 1'b1;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready)
      begin
        wd_q <= s_wdata;
        w_h_q <= 1'b1;
        s_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_bvalid <= 1'b1;
        s_bresp <= (awa_q > 8'h7C || awa_q[1:0] != 2'h0) ?
          `BAF_RESP_ERR : `BAF_RESP_OK;
      end
      if (s_bvalid && s_bready)
      begin
        s_bvalid <= 1'b0;
        aw_h_q <= 1'b0;
        w_h_q <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  // plain configuration registers; table commands are queued
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mac_q <= 48'h0;
      dmac_q <= 48'h0;
      restr_q <= 16'h0;
      mcl_q <= 24'h0;
      cmd_q <= 10'h0;
      for (i = 0; i < NP; i = i + 1)
        bset[i] <= {NP{1'b1}};
    end
    else if (ce && wr_go)
    begin
      if (awa_q == `BAF_MAC_LO)
        mac_q[31:0] <= wd_q;
      else if (awa_q == `BAF_MAC_HI)
        mac_q[47:32] <= wd_q[15:0];
      else if (awa_q == `BAF_DMAC_LO)
        dmac_q[31:0] <= wd_q;
      else if (awa_q == `BAF_DMAC_HI)
        dmac_q[47:32] <= wd_q[15:0];
      else if (awa_q == `BAF_RESTR)
        restr_q <= wd_q[15:0];
      else if (awa_q == `BAF_MCL)
        mcl_q <= wd_q[23:0];
      else if (awa_q == `BAF_TBL_CMD)
        cmd_q <= wd_q[9:0];
      else if (awa_q[7:5] == 3'h2)
        bset[awa_q[4:2]] <= wd_q[NP-1:0];
    end
  end

  // filter pool: index in low bits, fields above
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (i = 0; i < NF; i = i + 1)
        fcfg[i] <= 12'h0;
    end
    else if (ce && wr_go && awa_q == `BAF_FILT_CMD && wd_q[6:0] < NF)
    begin
      fcfg[wd_q[6:0]] <= wd_q[19:8];
      fsrc[wd_q[6:0]] <= mac_q;
      fdst[wd_q[6:0]] <= dmac_q;
    end
  end

  // axi read channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= `BAF_RESP_OK;
    end
    else if (ce)
    begin
      if (s_arvalid && s_arready)
      begin
        s_arready <= 1'b0;
        s_rvalid <= 1'b1;
        s_rresp <= `BAF_RESP_OK;
        s_rdata <= 32'h0;
        if (s_araddr == `BAF_PORT_EN)
          s_rdata[NP-1:0] <= port_en_q;
        else if (s_araddr == `BAF_TBL_STAT)
          s_rdata <= {22'h0, cmd_pend_q, full_err_q, scnt_q};
        else if (s_araddr == `BAF_RESTR)
          s_rdata[15:0] <= restr_q;
        else if (s_araddr == `BAF_MCL)
          s_rdata[23:0] <= mcl_q;
        else if (s_araddr == `BAF_PSEUDO_CNT)
          s_rdata[15:0] <= pseudo_q;
        else if (s_araddr == `BAF_LOOKUP)
          s_rdata <= look_q;
        else if (s_araddr[7:5] == 3'h2 && s_araddr[1:0] == 2'h0)
          s_rdata[NP-1:0] <= bset[s_araddr[4:2]];
        else if (s_araddr[7:5] == 3'h3 && s_araddr[1:0] == 2'h0)
          s_rdata[15:0] <= stat[s_araddr[4:2]];
        else if (s_araddr > 8'h38 || s_araddr[1:0] != 2'h0)
          s_rresp <= `BAF_RESP_ERR;
      end
      if (s_rvalid && s_rready)
      begin
        s_rvalid <= 1'b0;
        s_arready <= 1'b1;
      end
    end
  end

  // frame engine and table management share the single table port
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= S_IDLE;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
      out_drop <= 1'b0;
      out_mask <= {NP{1'b0}};
      cmd_pend_q <= 1'b0;
      full_err_q <= 1'b0;
      scnt_q <= 8'h0;
      pseudo_q <= 16'h0;
      look_q <= 32'h0;
      addr_q <= {AW{1'b0}};
      rd_q <= 72'h0;
      src_q <= 48'h0;
      dst_q <= 48'h0;
      rxp_q <= 3'h0;
      drop_q <= 1'b0;
      src_stat_q <= 1'b0;
      mask_q <= {NP{1'b0}};
      fi_q <= 7'h0;
      int_q <= 8'h0;
      for (i = 0; i < NP; i = i + 1)
      begin
        stat[i] <= 16'h0;
        mcc[i] <= 8'h0;
      end
      for (i = 0; i < (1 << AW); i = i + 1)
        tbl[i] <= 72'h0;
    end
    else if (ce)
    begin
      rd_q <= tbl[addr_q];
      out_valid <= 1'b0;
      if (wr_go && awa_q == `BAF_TBL_CMD)
      begin
        cmd_pend_q <= 1'b1;
        full_err_q <= 1'b0;
      end
      if (wr_go && awa_q == `BAF_EN_CMD)
        for (i = 0; i < NP; i = i + 1)
          if (wd_q[i] && port_en_q[i])
            stat[i] <= 16'h0; // [RQ18]
      if (sec_tick)
      begin
        int_q <= int_q + 8'h1;
        if (int_q + 8'h1 >= mcl_q[23:16])
        begin
          int_q <= 8'h0;
          for (i = 0; i < NP; i = i + 1)
            mcc[i] <= 8'h0; // [RQ14]
        end
      end
      case (st_q)
        S_IDLE:
        begin
          // a command landing now must not leave ready up with nobody taking
          in_ready <= !cmd_pend_q && !tbl_go;
          if (cmd_pend_q)
          begin
            in_ready <= 1'b0;
            addr_q <= hsh(mac_q);
            st_q <= S_MG1;
          end
          else if (in_valid && in_ready)
          begin
            in_ready <= 1'b0;
            src_q <= in_src;
            dst_q <= in_dst;
            rxp_q <= in_port;
            addr_q <= hsh(in_src);
            stat[in_port] <= stat[in_port] + 16'h1;
            st_q <= S_SRC;
          end
        end
        S_SRC:
        begin
          // destination read issued now so it lands before the scan
          addr_q <= hsh(dst_q);
          st_q <= S_DST;
        end
        S_DST:
        begin
          drop_q <= !port_en_q[rxp_q]; // [RQ19]
          src_stat_q <= hit && rd[`BAF_E_STAT];
          if (hit && rd[`BAF_E_SF])
            drop_q <= 1'b1; // [RQ5]
          if (hit && rd[`BAF_E_MSF] && mcast)
            drop_q <= 1'b1; // [RQ6]
          if (restr_q[rxp_q] && !(hit && rd[`BAF_E_STAT]))
            drop_q <= 1'b1; // [RQ11]
          // a disabled port neither refreshes nor learns
          if (hit && port_en_q[rxp_q])
          begin
            tbl[hsh(src_q)][`BAF_E_STAMP] <= now_q; // [RQ4]
            if (!rd[`BAF_E_STAT])
              tbl[hsh(src_q)][`BAF_E_PORT] <= rxp_q; // [RQ3]
          end
          else if (port_en_q[rxp_q] && !src_q[40] &&
                   !(rd[`BAF_E_VLD] && rd[`BAF_E_STAT]))
            tbl[hsh(src_q)] <= {5'b10000, rxp_q, now_q, src_q}; // [RQ21]
          st_q <= S_FILT;
          fi_q <= 7'h0;
        end
        S_FILT:
        begin
          if (fi_q == 7'h0)
          begin
            mask_q <= dmask & port_en_q; // [RQ22]
            if (dhit && rd[`BAF_E_NUL])
              drop_q <= 1'b1; // [RQ8]
          end
          // one filter per cycle keeps the pool in plain registers
          if (f_all && fi_q != 7'h0 && !fc[1] && fc[5:3] == rxp_q)
          begin
            if (fc[2])
              pseudo_q <= pseudo_q + 16'h1; // [RQ20]
            else
              drop_q <= 1'b1; // [RQ13]
          end
          if (f_all && fi_q != 7'h0 && fc[1] && f_rxp_ok &&
              mask_q[fc[5:3]])
          begin
            if (fc[2])
              pseudo_q <= pseudo_q + 16'h1;
            else
              mask_q[fc[5:3]] <= 1'b0; // [RQ15]
          end
          if (fi_q == NF - 1)
            st_q <= S_OUT;
          if (fi_q == 7'h0 && dhit)
            fi_q <= 7'h0;
          fi_q <= fi_q + 7'h1;
        end
        S_OUT:
        begin
          out_valid <= 1'b1;
          out_drop <= drop_q;
          out_mask <= drop_q ? {NP{1'b0}} : mask_q;
          for (i = 0; i < NP; i = i + 1)
            if (!drop_q && mask_q[i] && mcast && mcl_q[i])
            begin
              if (mcc[i] >= mcl_q[15:8])
                out_mask[i] <= 1'b0; // [RQ14]
              else
                mcc[i] <= mcc[i] + 8'h1;
            end
          in_ready <= !cmd_pend_q && !tbl_go;
          st_q <= S_IDLE;
        end
        S_MG1:
          st_q <= S_MG2;
        S_MG2:
        begin
          cmd_pend_q <= tbl_go; // a new command arriving now wins
          st_q <= S_IDLE;
          if (cmd_q[`BAF_CMD_OP] == `BAF_OP_LOOK)
            look_q <= {rd[`BAF_E_VLD] && rd[47:0] == mac_q,
              rd[`BAF_E_STAT], rd[`BAF_E_SF], rd[`BAF_E_MSF],
              rd[`BAF_E_NUL], rd[`BAF_E_PORT], 8'h00,
              now_q - rd[`BAF_E_STAMP]};
          else if (cmd_q[`BAF_CMD_OP] == `BAF_OP_DEL)
          begin
            if (rd[`BAF_E_VLD] && rd[`BAF_E_STAT] && rd[47:0] == mac_q)
            begin
              tbl[addr_q] <= 72'h0;
              scnt_q <= scnt_q - 8'h1;
            end
          end
          else if (rd[`BAF_E_VLD] && rd[`BAF_E_STAT] && rd[47:0] == mac_q)
            tbl[addr_q] <= {2'b11, cmd_q[`BAF_CMD_SF],
              cmd_q[`BAF_CMD_MSF], cmd_q[`BAF_CMD_NUL], cmd_q[2:0],
              now_q, mac_q}; // [RQ3]
          else if (scnt_q < `BAF_STATIC_MAX &&
                   !(rd[`BAF_E_VLD] && rd[`BAF_E_STAT]))
          begin
            tbl[addr_q] <= {2'b11, cmd_q[`BAF_CMD_SF],
              cmd_q[`BAF_CMD_MSF], cmd_q[`BAF_CMD_NUL], cmd_q[2:0],
              now_q, mac_q}; // [RQ9]
            scnt_q <= scnt_q + 8'h1;
          end
          else
            full_err_q <= 1'b1; // [RQ2]
        end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end
endmodule // bridge_address_filter

//--- sim/baf_checker.sv
// checker: handshake and decision timing at the filter's ports
// assumes one aclk domain and ce held high by the bench
`timescale 1ns/1ps
module baf_checker #(
  parameter NP = 8
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // register bus handshakes
  input wire s_awvalid,
  input wire s_awready,
  input wire s_bvalid,
  input wire s_bready,
  input wire s_arvalid,
  input wire s_arready,
  input wire s_rvalid,
  input wire s_rready,
  input wire [31:0] s_rdata,
  // frame side
  input wire in_valid,
  input wire in_ready,
  input wire out_valid,
  input wire out_drop,
  input wire [NP-1:0] out_mask
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_drop_empty;
    out_valid && out_drop |-> out_mask == 0;
  endproperty
  a_drop_empty: assert property (p_drop_empty)
    else $error("dropped frame still has ports");
  property p_pulse;
    out_valid |=> !out_valid;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("decision pulse longer than one cycle");
  // decision lands 103 to 104 cycles after the take
  property p_latency;
    in_valid && in_ready |-> ##[103:104] out_valid;
  endproperty
  a_latency: assert property (p_latency)
    else $error("decision not on time");
  property p_busy;
    in_valid && in_ready |=> !in_ready [*8];
  endproperty
  a_busy: assert property (p_busy)
    else $error("frame taken while busy");
  property p_bhold;
    s_bvalid && !s_bready |=> s_bvalid;
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped early");
  property p_rhold;
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data not held");
  property p_rlat;
    s_arvalid && s_arready |=> s_rvalid;
  endproperty
  a_rlat: assert property (p_rlat)
    else $error("read answer late");
  property p_awbusy;
    s_awvalid && s_awready |=> !s_awready;
  endproperty
  a_awbusy: assert property (p_awbusy)
    else $error("second write accepted");
endmodule // baf_checker

bind bridge_address_filter baf_checker #(.NP(NP)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_awvalid(s_awvalid),
  .s_awready(s_awready), .s_bvalid(s_bvalid), .s_bready(s_bready),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid),
  .s_rready(s_rready), .s_rdata(s_rdata), .in_valid(in_valid),
  .in_ready(in_ready), .out_valid(out_valid), .out_drop(out_drop),
  .out_mask(out_mask));

//--- sim/port_mac_model.sv
// port side model: offers frame descriptors, collects decisions
// assumes registered in_ready and out_valid on aclk
`timescale 1ns/1ps
module port_mac_model (
  // clock
  input wire aclk,
  // descriptor offer
  output reg in_valid,
  input wire in_ready,
  output reg [47:0] in_src,
  output reg [47:0] in_dst,
  output reg [2:0] in_port,
  // decision
  input wire out_valid,
  input wire out_drop,
  input wire [7:0] out_mask
);
  reg got_drop;
  reg [7:0] got_mask;
  integer g;
  initial
  begin
    in_valid = 1'b0;
    in_src = 48'h0;
    in_dst = 48'h0;
    in_port = 3'h0;
  end
  // registered flags are read mid-cycle to dodge edge races
  task send(input [47:0] s, input [47:0] d, input [2:0] p);
    begin
      @(posedge aclk);
      in_valid <= 1'b1;
      in_src <= s;
      in_dst <= d;
      in_port <= p;
      g = 0;
      do
      begin
        @(negedge aclk);
        g = g + 1;
      end while (!in_ready && g < 400);
      @(posedge aclk);
      // released lines must not keep looking valid
      in_valid <= 1'b0;
      in_src <= ~s;
      in_dst <= ~d;
      in_port <= ~p;
      got_drop = 1'bx;
      got_mask = 8'hXX;
      g = 0;
      while (!out_valid && g < 300)
      begin
        @(negedge aclk);
        g = g + 1;
      end
      if (out_valid)
      begin
        got_drop = out_drop;
        got_mask = out_mask;
      end
    end
  endtask
endmodule // port_mac_model

//--- sim/tb_top.sv
// bench: register and frame sequences against the address filter
// assumes ce held high and the port model on the descriptor side
`timescale 1ns/1ps
`include "baf_defines.vh"
module tb_top;
  reg aclk, aresetn, cold_rst_n, ce;
  reg [7:0] s_awaddr, s_araddr;
  reg [31:0] s_wdata;
  reg [3:0] s_wstrb;
  reg s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  wire [1:0] s_bresp, s_rresp;
  wire [31:0] s_rdata;
  wire in_valid, in_ready, out_valid, out_drop;
  wire [47:0] in_src, in_dst;
  wire [2:0] in_port;
  wire [7:0] out_mask;
  integer failures, n_checks, g;
  reg [31:0] rd;
  reg [1:0] rr;
  localparam [47:0] m_a = 48'h0000_0000_0A01;
  localparam [47:0] m_b = 48'h0000_0000_0B02;
  localparam [47:0] m_c = 48'h0000_0000_0C03;
  localparam [47:0] m_d = 48'h0000_0000_0D04;
  localparam [47:0] m_e = 48'h0000_0000_0E05;
  localparam [47:0] m_mc = 48'h0100_0000_0B02;
  localparam [47:0] m_bc = 48'hFFFF_FFFF_FFFF;

  bridge_address_filter #(.NP(8), .SEC_CYCLES(20)) dut (
    .aclk(aclk), .aresetn(aresetn), .cold_rst_n(cold_rst_n), .ce(ce),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .in_valid(in_valid),
    .in_ready(in_ready), .in_src(in_src), .in_dst(in_dst),
    .in_port(in_port), .out_valid(out_valid), .out_drop(out_drop),
    .out_mask(out_mask));
  port_mac_model mac (.aclk(aclk), .in_valid(in_valid),
    .in_ready(in_ready), .in_src(in_src), .in_dst(in_dst),
    .in_port(in_port), .out_valid(out_valid), .out_drop(out_drop),
    .out_mask(out_mask));

  // 40 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task chk(input [63:0] nm, input [31:0] e, input [31:0] v);
    begin
      n_checks = n_checks + 1;
      if (v !== e)
      begin
        failures = failures + 1;
        $display("BAD %0s expected %h seen %h", nm, e, v);
      end
    end
  endtask
  // ready and valid are read mid-cycle, released after the edge
  task wr(input [7:0] a, input [31:0] d);
    reg ta, tw, tb;
    begin
      @(posedge aclk);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      g = 0;
      do
      begin
        @(negedge aclk);
        ta = s_awvalid && s_awready;
        tw = s_wvalid && s_wready;
        tb = s_bvalid;
        g = g + 1;
        @(posedge aclk);
        if (ta) s_awvalid <= 1'b0;
        if (tw) s_wvalid <= 1'b0;
      end while (!tb && g < 200);
      s_bready <= 1'b0;
      if (!tb) chk("wr_to", 1, 0);
    end
  endtask
  task rdw(input [7:0] a);
    reg ta, tr;
    begin
      @(posedge aclk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      g = 0;
      do
      begin
        @(negedge aclk);
        ta = s_arvalid && s_arready;
        tr = s_rvalid;
        rd = s_rdata;
        rr = s_rresp;
        g = g + 1;
        @(posedge aclk);
        if (ta) s_arvalid <= 1'b0;
      end while (!tr && g < 200);
      s_rready <= 1'b0;
      if (!tr) chk("rd_to", 1, 0);
    end
  endtask
  task setmac(input [47:0] m);
    begin
      wr(`BAF_MAC_LO, m[31:0]);
      wr(`BAF_MAC_HI, {16'h0, m[47:32]});
    end
  endtask
  task frm(input [47:0] s, d, input [2:0] p, input dr, input [7:0] mk);
    begin
      mac.send(s, d, p);
      chk("drop", dr, mac.got_drop);
      chk("mask", mk, mac.got_mask);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // watchdog far beyond the expected few thousand cycles
  initial
  begin
    #(25 * 40000);
    failures = failures + 1;
    print_verdict;
  end
  // main sequence
  initial
  begin
    failures = 0;
    n_checks = 0;
    {aresetn, cold_rst_n, ce, s_wstrb} = {3'b001, 4'hF};
    {s_awaddr, s_araddr, s_wdata} = 48'h0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    cold_rst_n <= 1'b1;
    rdw(`BAF_PORT_EN); chk("port_en", 32'hFF, rd);
    rdw(8'h80); chk("unmapped", 2, rr);
    mac.send(m_b, m_a, 3'h2);
    frm(m_a, m_b, 1, 0, 8'h04);
    setmac(m_b); wr(`BAF_TBL_CMD, 32'h5);
    frm(m_a, m_b, 1, 0, 8'h20);
    setmac(m_c); wr(`BAF_TBL_CMD, 32'h10);
    frm(m_a, m_c, 1, 1, 8'h00);
    setmac(m_d); wr(`BAF_TBL_CMD, 32'h23);
    frm(m_d, m_b, 1, 1, 8'h00);
    frm(m_a, m_d, 1, 0, 8'h08);
    setmac(m_e); wr(`BAF_TBL_CMD, 32'h44);
    frm(m_e, m_b, 1, 0, 8'h20);
    frm(m_e, m_mc, 1, 1, 8'h00);
    rdw(`BAF_TBL_STAT); chk("statics", 4, rd[7:0]);
    wr(`BAF_RESTR, 32'h2);
    frm(m_a, m_b, 1, 1, 8'h00);
    frm(m_b, m_d, 1, 0, 8'h08);
    wr(`BAF_BSET + 8'h04, 32'h0C); wr(`BAF_RESTR, 32'h0);
    frm(m_a, m_bc, 1, 0, 8'h0C);
    wr(`BAF_RESTR, 32'h200);
    frm(m_a, m_a, 1, 0, 8'h0C);
    wr(`BAF_RESTR, 32'h0);
    setmac(m_a); wr(`BAF_FILT_CMD, 32'h0004_0901);
    frm(m_a, m_b, 1, 1, 8'h00);
    wr(`BAF_FILT_CMD, 32'h0004_0D01);
    frm(m_a, m_b, 1, 0, 8'h20);
    rdw(`BAF_PSEUDO_CNT); chk("pseudo", 1, rd);
    wr(`BAF_FILT_CMD, 32'h1);
    wr(`BAF_DIS_CMD, 32'h2);
    rdw(`BAF_PORT_EN); chk("port_en", 32'hFD, rd);
    frm(m_a, m_b, 1, 1, 8'h00);
    wr(`BAF_EN_CMD, 32'h2);
    frm(m_a, m_b, 1, 0, 8'h20);
    wr(`BAF_EN_CMD, 32'h2);
    rdw(`BAF_STATS + 8'h04); chk("stats", 0, rd);
    // warm reset must leave the disabled port off
    wr(`BAF_DIS_CMD, 32'h8);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdw(`BAF_PORT_EN); chk("port_en", 32'hF7, rd);
    // multicast limit on port 5: one per long interval
    wr(`BAF_MCL, 32'h00FF_0120);
    frm(m_a, m_mc, 1, 0, 8'hF5);
    frm(m_a, m_mc, 1, 0, 8'hD5);
    // lookup of the learned source after some seconds
    repeat (100) @(posedge aclk);
    setmac(m_a);
    wr(`BAF_TBL_CMD, 32'h200);
    repeat (4) @(posedge aclk);
    rdw(`BAF_LOOKUP);
    chk("look", 32'h8100, rd[31:16]);
    chk("age", 1, rd[15:0] > 4 && rd[15:0] < 16);
    // static add then delete moves the static count
    setmac(m_e);
    wr(`BAF_TBL_CMD, 32'h4);
    repeat (4) @(posedge aclk);
    rdw(`BAF_TBL_STAT);
    chk("statics", 1, rd[7:0]);
    wr(`BAF_TBL_CMD, 32'h100);
    repeat (4) @(posedge aclk);
    rdw(`BAF_TBL_STAT);
    chk("statics", 0, rd[7:0]);
    print_verdict;
  end
endmodule // tb_top
